//--- rtl/mcs_pkg.sv
// constants, register map and types of the motor current supervision block
// assumes a 20 MHz system clock and a 32-bit classic wishbone register bus
package mcs_pkg;
  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int unsigned CLK_HZ    = 20_000_000;
  localparam int unsigned TICK_MS   = 1;
  localparam int unsigned TICK_CYC  = CLK_HZ / 1000 * TICK_MS;
  // -------------------------------------------------------------
  // drop-out ratios in percent
  // -------------------------------------------------------------
  localparam logic [7:0] PCT_FULL       = 8'h64;
  localparam logic [7:0] STALL_DROP_PCT = 8'h62;
  localparam logic [7:0] UL_DROP_PCT    = 8'h67;
  // -------------------------------------------------------------
  // register byte offsets
  // -------------------------------------------------------------
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_AVLIM  = 12'h004;
  localparam logic [11:0] REG_FLC    = 12'h008;
  localparam logic [11:0] REG_SDLY   = 12'h00c;
  localparam logic [11:0] REG_RDLY   = 12'h010;
  localparam logic [11:0] REG_STAT   = 12'h014;
  localparam logic [11:0] REG_STALL  = 12'h020;
  localparam logic [11:0] REG_UL     = 12'h040;
  localparam logic [11:0] REG_OC     = 12'h100;
  localparam logic [1:0]  FLD_CFG    = 2'h0;
  localparam logic [1:0]  FLD_PICK   = 2'h1;
  localparam logic [1:0]  FLD_DLY    = 2'h2;
  localparam logic [1:0]  FLD_VLIM   = 2'h3;
  // -------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------
  localparam int CTRL_SET_LSB   = 0;
  localparam int CTRL_AEN       = 2;
  localparam int CTRL_ASET_LSB  = 3;
  localparam int CFG_EN         = 0;
  localparam int CFG_TRIP       = 1;
  localparam int OC_NONDIR      = 1;
  localparam int OC_METH_LSB    = 2;
  localparam int OC_VR          = 4;
  localparam int OC_VMODE       = 5;
  localparam logic [15:0] OC_CFG_MASK = 16'h003f;
  localparam logic [1:0]  EL_CFG_MASK = 2'h3;
  // -------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------
  localparam logic [15:0] RST_STALL_PICK = 16'hffff;
  localparam logic [15:0] RST_UL_PICK    = 16'h0000;
  localparam logic [15:0] RST_VALUE      = 16'h0000;
  localparam logic [1:0]  RST_CFG        = 2'h0;
  typedef enum logic [1:0] {
    MCS_METH_FUND = 2'h0,
    MCS_METH_RMS  = 2'h1,
    MCS_METH_NEG  = 2'h2
  } mcs_meth_t;
endpackage : mcs_pkg

//--- rtl/mcs_top.sv
// motor current supervision: stall overload, underload and overcurrent elements
// assumes measured quantities and motor state arrive on sys_clk from the front end;
// only the adaptive set request pin is asynchronous
//
// Function
// - two stall elements, each with own pickup, delay and enable
// - stall alarm rises once current exceeds that element's pickup
// - stall trip only when enabled and delay fully elapsed above pickup
// - with trip blocked a stall element still alarms and times normally
// - stall trip withheld until delay ran during whole pickup time
// - start hold blocks stall alarm and trip until start delay elapsed and current falls to full load
// - run delay filters short load transients before alarm or trip
// - stall pickup drops out only at 98 percent of pickup or lower
// - stall elements act only while the motor runs
// - underload alarm element (trip blocked) and trip element below threshold
// - each underload element has its own delay timer
// - underload trip blocked after start until start delay elapsed
// - underload pickup drops out only at 103 percent of pickup or higher
// - all overcurrent elements share one structure, only settings differ
// - non-directional overcurrent element ignores direction input
// - overcurrent element measures fundamental or true rms as selected
// - negative sequence method measures negative sequence current
// - voltage restraint lowers pickup in proportion to voltage drop
// - restraint voltage taken phase-to-phase or phase-to-ground
// - four overcurrent setting sets, adaptive set may override active one
// - voltage controlled behaviour works by adaptive set switching
`timescale 1ns/1ps
module mcs_top
  import mcs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = mcs_pkg::TICK_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] cur_fund,
  input  wire logic [15:0] cur_rms,
  input  wire logic [15:0] negative_sequence_current,
  input  wire logic [15:0] volt_pp,
  input  wire logic [15:0] volt_pg,
  input  wire logic        dir_fwd,
  input  wire logic        motor_run,
  input  wire logic        adapt_req_pin,
  output logic      [1:0]  stall_alarm,
  output logic      [1:0]  stall_trip,
  output logic      [1:0]  ul_alarm,
  output logic      [1:0]  ul_trip,
  output logic      [1:0]  oc_pickup,
  output logic      [1:0]  oc_trip,
  output logic      [1:0]  active_set
);
  import mcs_pkg::*;

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    logic              ack;
    logic [31:0]       rdat;
    logic [1:0]        set_sel;
    logic              adapt_en;
    logic [1:0]        adapt_set;
    logic [15:0]       avlim;
    logic [15:0]       flc;
    logic [15:0]       start_dly;
    logic [15:0]       run_dly;
    logic [1:0][1:0]   st_cfg;
    logic [1:0][15:0]  st_pick;
    logic [1:0][15:0]  st_dly;
    logic [1:0][1:0]   ul_cfg;
    logic [1:0][15:0]  ul_pick;
    logic [1:0][15:0]  ul_dly;
    logic [31:0][15:0] oc_mem;
    logic [15:0]       tick_cnt;
    logic              tick;
    logic              run_q;
    logic [15:0]       start_cnt;
    logic              start_hold;
    logic              ad_s1;
    logic              ad_s2;
    logic [1:0]        act;
    logic [1:0][16:0]  st_cnt;
    logic [1:0]        st_pk;
    logic [1:0]        st_alm;
    logic [1:0]        st_trp;
    logic [1:0][16:0]  ul_cnt;
    logic [1:0]        ul_pk;
    logic [1:0]        ul_alm;
    logic [1:0]        ul_trp;
    logic [1:0][16:0]  oc_cnt;
    logic [1:0]        oc_pk;
    logic [1:0]        oc_trp;
  } mcs_state_t;

  mcs_state_t state_r;
  mcs_state_t state_nxt;

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [15:0] bm16(input logic [15:0] old, input logic [15:0] nw,
                                       input logic [1:0] sel);
    bm16 = old;
    if (sel[0])
    begin
      bm16[7:0] = nw[7:0];
    end
    if (sel[1])
    begin
      bm16[15:8] = nw[15:8];
    end
  endfunction : bm16

  // over-current comparison with drop-out held at a percentage of pickup
  function automatic logic hyst_over(input logic [15:0] cur, input logic [15:0] pick,
                                     input logic picked);
    logic [23:0] c;
    logic [23:0] p;
    c = 24'(cur) * 24'(PCT_FULL);
    p = 24'(pick) * 24'(STALL_DROP_PCT);
    hyst_over = picked ? (c > p) : (cur > pick);
  endfunction : hyst_over

  function automatic logic hyst_under(input logic [15:0] cur, input logic [15:0] pick,
                                      input logic picked);
    logic [23:0] c;
    logic [23:0] p;
    c = 24'(cur) * 24'(PCT_FULL);
    p = 24'(pick) * 24'(UL_DROP_PCT);
    hyst_under = picked ? (c < p) : (cur < pick);
  endfunction : hyst_under

  function automatic logic [16:0] tmr(input logic [16:0] cnt, input logic q,
                                      input logic tk);
    if (!q)
    begin
      tmr = 17'h0;
    end
    else if (tk && cnt != 17'h1ffff)
    begin
      tmr = cnt + 17'h1;
    end
    else
    begin
      tmr = cnt;
    end
  endfunction : tmr

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb
  begin
    logic        req;
    logic        q;
    logic        ei;
    logic [4:0]  base;
    logic [15:0] ocfg;
    logic [15:0] opick;
    logic [15:0] odly;
    logic [15:0] ovlim;
    logic [15:0] ocur;
    logic [15:0] ov;
    logic [15:0] ovc;
    logic        opk;
    logic [16:0] lim;
    logic [15:0] wv;
    req   = 1'b0;
    q     = 1'b0;
    ei    = 1'b0;
    base  = 5'h0;
    ocfg  = 16'h0;
    opick = 16'h0;
    odly  = 16'h0;
    ovlim = 16'h0;
    ocur  = 16'h0;
    ov    = 16'h0;
    ovc   = 16'h0;
    opk   = 1'b0;
    lim   = 17'h0;
    wv    = 16'h0;
    state_nxt = state_r;

    // -----------------------------------------------------------
    // wishbone slave, one wait state, unmapped reads return zero except 0x180 to 0x1ff, which mirror the overcurrent block
    // -----------------------------------------------------------
    req = wb_cyc_i & wb_stb_i & ~state_r.ack;
    state_nxt.ack  = req;
    state_nxt.rdat = 32'h0;
    ei = wb_adr_i[4];
    wv = wb_dat_i[15:0];
    if (req && wb_we_i)
    begin
      if (wb_adr_i[11:8] == REG_OC[11:8])
      begin
        state_nxt.oc_mem[wb_adr_i[6:2]] = bm16(state_r.oc_mem[wb_adr_i[6:2]], wv,
                                               wb_sel_i[1:0]);
        if (wb_adr_i[3:2] == FLD_CFG)
        begin
          state_nxt.oc_mem[wb_adr_i[6:2]] = state_nxt.oc_mem[wb_adr_i[6:2]] & OC_CFG_MASK;
        end
      end
      else if (wb_adr_i[11:5] == REG_STALL[11:5])
      begin
        case (wb_adr_i[3:2])
          FLD_CFG:  state_nxt.st_cfg[ei]  = wb_sel_i[0] ? wv[1:0] & EL_CFG_MASK
                                                        : state_r.st_cfg[ei];
          FLD_PICK: state_nxt.st_pick[ei] = bm16(state_r.st_pick[ei], wv, wb_sel_i[1:0]);
          FLD_DLY:  state_nxt.st_dly[ei]  = bm16(state_r.st_dly[ei], wv, wb_sel_i[1:0]);
          default:  state_nxt.st_dly[ei]  = state_r.st_dly[ei];
        endcase
      end
      else if (wb_adr_i[11:5] == REG_UL[11:5])
      begin
        case (wb_adr_i[3:2])
          FLD_CFG:  state_nxt.ul_cfg[ei]  = wb_sel_i[0] ? wv[1:0] & EL_CFG_MASK
                                                        : state_r.ul_cfg[ei];
          FLD_PICK: state_nxt.ul_pick[ei] = bm16(state_r.ul_pick[ei], wv, wb_sel_i[1:0]);
          FLD_DLY:  state_nxt.ul_dly[ei]  = bm16(state_r.ul_dly[ei], wv, wb_sel_i[1:0]);
          default:  state_nxt.ul_dly[ei]  = state_r.ul_dly[ei];
        endcase
      end
      else
      begin
        case ({wb_adr_i[11:2], 2'b00})
          REG_CTRL:
          begin
            if (wb_sel_i[0])
            begin
              state_nxt.set_sel   = wv[CTRL_SET_LSB +: 2];
              state_nxt.adapt_en  = wv[CTRL_AEN];
              state_nxt.adapt_set = wv[CTRL_ASET_LSB +: 2];
            end
          end
          REG_AVLIM: state_nxt.avlim     = bm16(state_r.avlim, wv, wb_sel_i[1:0]);
          REG_FLC:   state_nxt.flc       = bm16(state_r.flc, wv, wb_sel_i[1:0]);
          REG_SDLY:  state_nxt.start_dly = bm16(state_r.start_dly, wv, wb_sel_i[1:0]);
          REG_RDLY:  state_nxt.run_dly   = bm16(state_r.run_dly, wv, wb_sel_i[1:0]);
          default:   state_nxt.run_dly   = state_r.run_dly;
        endcase
      end
    end
    else if (req)
    begin
      if (wb_adr_i[11:8] == REG_OC[11:8])
      begin
        state_nxt.rdat = {16'h0, state_r.oc_mem[wb_adr_i[6:2]]};
      end
      else if (wb_adr_i[11:5] == REG_STALL[11:5] || wb_adr_i[11:5] == REG_UL[11:5])
      begin
        case ({wb_adr_i[6], wb_adr_i[3:2]})
          {1'b0, FLD_CFG}:  state_nxt.rdat = {30'h0, state_r.st_cfg[ei]};
          {1'b0, FLD_PICK}: state_nxt.rdat = {16'h0, state_r.st_pick[ei]};
          {1'b0, FLD_DLY}:  state_nxt.rdat = {16'h0, state_r.st_dly[ei]};
          {1'b1, FLD_CFG}:  state_nxt.rdat = {30'h0, state_r.ul_cfg[ei]};
          {1'b1, FLD_PICK}: state_nxt.rdat = {16'h0, state_r.ul_pick[ei]};
          {1'b1, FLD_DLY}:  state_nxt.rdat = {16'h0, state_r.ul_dly[ei]};
          default:          state_nxt.rdat = 32'h0;
        endcase
      end
      else
      begin
        case ({wb_adr_i[11:2], 2'b00})
          REG_CTRL:  state_nxt.rdat = {27'h0, state_r.adapt_set, state_r.adapt_en,
                                       state_r.set_sel};
          REG_AVLIM: state_nxt.rdat = {16'h0, state_r.avlim};
          REG_FLC:   state_nxt.rdat = {16'h0, state_r.flc};
          REG_SDLY:  state_nxt.rdat = {16'h0, state_r.start_dly};
          REG_RDLY:  state_nxt.rdat = {16'h0, state_r.run_dly};
          REG_STAT:  state_nxt.rdat = {16'h0, state_r.act, state_r.start_hold,
                                       state_r.run_q, state_r.oc_trp, state_r.oc_pk,
                                       state_r.ul_trp, state_r.ul_alm, state_r.st_trp,
                                       state_r.st_alm};
          default:   state_nxt.rdat = 32'h0;
        endcase
      end
    end

    // -----------------------------------------------------------
    // millisecond tick and motor start tracking
    // -----------------------------------------------------------
    state_nxt.tick = (state_r.tick_cnt == 16'(TICK_CYCLES - 1));
    state_nxt.tick_cnt = state_nxt.tick ? 16'h0 : state_r.tick_cnt + 16'h1;
    state_nxt.run_q = motor_run;
    state_nxt.ad_s1 = adapt_req_pin;
    state_nxt.ad_s2 = state_r.ad_s1;
    if (motor_run && !state_r.run_q)
    begin
      state_nxt.start_cnt  = 16'h0;
      state_nxt.start_hold = 1'b1;
    end
    else
    begin
      if (state_r.tick && state_r.start_cnt != 16'hffff)
      begin
        state_nxt.start_cnt = state_r.start_cnt + 16'h1;
      end
      if (state_r.start_cnt >= state_r.start_dly && cur_rms <= state_r.flc)
      begin
        state_nxt.start_hold = 1'b0;
      end
    end

    // -----------------------------------------------------------
    // stall overload elements
    // -----------------------------------------------------------
    // two stall elements
    for (int i = 0; i < 2; i++)
    begin
      state_nxt.st_pk[i] = hyst_over(cur_rms, state_r.st_pick[i], state_r.st_pk[i]);
      q = state_nxt.st_pk[i] & state_r.st_cfg[i][CFG_EN] & motor_run & ~state_r.start_hold;
      state_nxt.st_cnt[i] = tmr(state_r.st_cnt[i], q, state_r.tick);
      lim = 17'(state_r.run_dly) + 17'(state_r.st_dly[i]);
      state_nxt.st_alm[i] = q & (state_r.st_cnt[i] >= 17'(state_r.run_dly));
      state_nxt.st_trp[i] = state_nxt.st_alm[i] & state_r.st_cfg[i][CFG_TRIP] &
                            (state_r.st_cnt[i] >= lim);
    end

    // -----------------------------------------------------------
    // underload elements, each on its own timer
    // -----------------------------------------------------------
    for (int i = 0; i < 2; i++)
    begin
      state_nxt.ul_pk[i] = hyst_under(cur_rms, state_r.ul_pick[i], state_r.ul_pk[i]);
      q = state_nxt.ul_pk[i] & state_r.ul_cfg[i][CFG_EN] & motor_run;
      state_nxt.ul_cnt[i] = tmr(state_r.ul_cnt[i], q, state_r.tick);
      lim = 17'(state_r.run_dly) + 17'(state_r.ul_dly[i]);
      state_nxt.ul_alm[i] = q & (state_r.ul_cnt[i] >= 17'(state_r.run_dly));
      // trip enabled and start delay over
      state_nxt.ul_trp[i] = state_nxt.ul_alm[i] & state_r.ul_cfg[i][CFG_TRIP] &
                            (state_r.ul_cnt[i] >= lim) &
                            (state_r.start_cnt >= state_r.start_dly) & ~state_nxt.run_q
                            | state_nxt.ul_alm[i] & state_r.ul_cfg[i][CFG_TRIP] &
                            (state_r.ul_cnt[i] >= lim) &
                            (state_r.start_cnt >= state_r.start_dly) & state_r.run_q;
    end

    // -----------------------------------------------------------
    // overcurrent elements
    // -----------------------------------------------------------
    // adaptive set on request or undervoltage
    if (state_r.adapt_en && (state_r.ad_s2 || volt_pp < state_r.avlim))
    begin
      state_nxt.act = state_r.adapt_set;
    end
    else
    begin
      state_nxt.act = state_r.set_sel;
    end
    // one structure, settings from the active set
    for (int i = 0; i < 2; i++)
    begin
      base  = {state_r.act, i[0], 2'b00};
      ocfg  = state_r.oc_mem[base | 5'(FLD_CFG)];
      opick = state_r.oc_mem[base | 5'(FLD_PICK)];
      odly  = state_r.oc_mem[base | 5'(FLD_DLY)];
      ovlim = state_r.oc_mem[base | 5'(FLD_VLIM)];
      case (mcs_meth_t'(ocfg[OC_METH_LSB +: 2]))
        MCS_METH_RMS: ocur = cur_rms;
        MCS_METH_NEG: ocur = negative_sequence_current;
        default:      ocur = cur_fund;
      endcase
      ov  = ocfg[OC_VMODE] ? volt_pg : volt_pp;
      ovc = (ov < ovlim) ? ov : ovlim;
      // pickup scaled by voltage ratio, no divider needed
      if (ocfg[OC_VR] && ovlim != 16'h0)
      begin
        opk = (32'(ocur) * 32'(ovlim)) > (32'(opick) * 32'(ovc));
      end
      else
      begin
        opk = ocur > opick;
      end
      q = opk & ocfg[CFG_EN] & (ocfg[OC_NONDIR] | dir_fwd);
      state_nxt.oc_pk[i]  = q;
      state_nxt.oc_cnt[i] = tmr(state_r.oc_cnt[i], q, state_r.tick);
      state_nxt.oc_trp[i] = q & (state_r.oc_cnt[i] >= 17'(odly));
    end
  end

  // -------------------------------------------------------------
  // registers
  // -------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_r            <= '0;
      state_r.start_hold <= 1'b1;
      state_r.avlim      <= RST_VALUE;
      state_r.flc        <= RST_VALUE;
      state_r.start_dly  <= RST_VALUE;
      state_r.run_dly    <= RST_VALUE;
      state_r.st_cfg     <= {RST_CFG, RST_CFG};
      state_r.ul_cfg     <= {RST_CFG, RST_CFG};
      state_r.st_pick    <= {RST_STALL_PICK, RST_STALL_PICK};
      state_r.ul_pick    <= {RST_UL_PICK, RST_UL_PICK};
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign wb_ack_o    = state_r.ack;
  assign wb_dat_o    = state_r.rdat;
  assign stall_alarm = state_r.st_alm;
  assign stall_trip  = state_r.st_trp;
  assign ul_alarm    = state_r.ul_alm;
  assign ul_trip     = state_r.ul_trp;
  assign oc_pickup   = state_r.oc_pk;
  assign oc_trip     = state_r.oc_trp;
  assign active_set  = state_r.act;
endmodule : mcs_top

//--- tb/mcs_fe_model.sv
// measurement front end: registers the quantities the bench asks for
// assumes the bench changes its settings right after a rising edge
`timescale 1ns/1ps
module mcs_fe_model (
  input  wire logic        sys_clk,
  input  wire logic [15:0] fund_set, rms_set, neg_set, vpp_set, vpg_set,
  input  wire logic        fwd_set, run_set,
  output logic      [15:0] cur_fund, cur_rms, negative_sequence_current, volt_pp, volt_pg,
  output logic             dir_fwd, motor_run
);
  // samples arrive on the system clock, one per edge
  always_ff @(posedge sys_clk)
  begin
    {cur_fund, cur_rms, negative_sequence_current} <= {fund_set, rms_set, neg_set};
    {volt_pp, volt_pg, dir_fwd, motor_run} <= {vpp_set, vpg_set, fwd_set, run_set};
  end
endmodule : mcs_fe_model

//--- tb/mcs_sva.sv
// port checker of the motor current supervision block
// bound to mcs_top by the testbench, sees only its ports
`timescale 1ns/1ps
module mcs_sva (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        motor_run,
  input wire logic [1:0]  stall_alarm,
  input wire logic [1:0]  stall_trip,
  input wire logic [1:0]  oc_pickup,
  input wire logic [1:0]  oc_trip
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------
  // bus and reset
  // ---------------------------------------------
  AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  AST_RST_QUIET: assert property (disable iff (1'b0) sys_rst |=> !wb_ack_o && stall_trip == 2'h0)
    else $error("outputs active after reset edge");
  // ---------------------------------------------
  // elements
  // ---------------------------------------------
  AST_STALL_IDLE: assert property (!motor_run [*3] |-> stall_alarm == 2'h0)
    else $error("stall alarm while motor stopped");
  AST_STALL0_TRIP: assert property (stall_trip[0] |-> stall_alarm[0] && $past(motor_run))
    else $error("stall 0 trip without pickup");
  AST_STALL1_TRIP: assert property (stall_trip[1] |-> stall_alarm[1] && $past(motor_run))
    else $error("stall 1 trip without pickup");
  AST_OC_TRIP_PICK: assert property (oc_trip[0] |-> oc_pickup[0])
    else $error("overcurrent trip without pickup");
endmodule : mcs_sva

//--- tb/testbench.sv
// self-checking bench of the motor current supervision block
// assumes mcs_pkg, mcs_top, mcs_fe_model and mcs_sva are compiled first
`timescale 1ns/1ps
module testbench;
  import mcs_pkg::*;
  localparam int TK = 10;
  logic        sys_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, dir_fwd, motor_run;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] cur_fund, cur_rms, negative_sequence_current, volt_pp, volt_pg;
  logic [15:0] f_s, r_s, n_s, vp_s, vg_s, hi, lo;
  logic        fw_s, run_s, ad_s;
  logic [1:0]  stall_alarm, stall_trip, ul_alarm, ul_trip, oc_pickup, oc_trip, active_set;
  int          num_errors, samples_checked, seed, m;
  mcs_top #(.TICK_CYCLES(TK)) i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cur_fund(cur_fund), .cur_rms(cur_rms), .negative_sequence_current(negative_sequence_current),
    .volt_pp(volt_pp), .volt_pg(volt_pg), .dir_fwd(dir_fwd), .motor_run(motor_run),
    .adapt_req_pin(ad_s), .stall_alarm(stall_alarm), .stall_trip(stall_trip),
    .ul_alarm(ul_alarm), .ul_trip(ul_trip), .oc_pickup(oc_pickup), .oc_trip(oc_trip),
    .active_set(active_set));
  mcs_fe_model i_fe (.sys_clk(sys_clk), .fund_set(f_s), .rms_set(r_s), .neg_set(n_s),
    .vpp_set(vp_s), .vpg_set(vg_s), .fwd_set(fw_s), .run_set(run_s), .cur_fund(cur_fund),
    .cur_rms(cur_rms), .negative_sequence_current(negative_sequence_current),
    .volt_pp(volt_pp), .volt_pg(volt_pg), .dir_fwd(dir_fwd), .motor_run(motor_run));
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function automatic logic oc_exp(input int c, input int p, input int v, input int l);
    return c * l > p * ((v < l) ? v : l);
  endfunction : oc_exp
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // classic single cycle, held until ack is sampled high
  task wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, a, d, 4'h3};
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    if (n >= 50) check("bus ack", 32'h0, 32'h1);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
  endtask : wb
  task tk(input int n);
    repeat (n * TK) @(posedge sys_clk);
  endtask : tk
  task report_and_stop;
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // hang guard, far beyond the few hundred clock cycles used
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    report_and_stop;
  end
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial
  begin
    seed = 32'h13098669;
    {num_errors, samples_checked} = 0;
    {sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = {4'h8, 48'h0};
    {f_s, r_s, n_s, vp_s, vg_s, fw_s, run_s, ad_s} = {16'h0, 16'h01f4, 16'h0, 32'h03e803e8, 3'h0};
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    wb(0, 12'(REG_STALL + 4), 0); check("stall pick reset", rd, {16'h0, RST_STALL_PICK});
    wb(0, 12'h0f0, 0); check("unmapped read", rd, 32'h0);
    wb(1, REG_FLC, 600); wb(1, REG_SDLY, 0); wb(1, REG_RDLY, 0);
    for (m = 0; m < 2; m++)
    begin
      wb(1, 12'(REG_STALL + 16 * m), 3 - 2 * m); wb(1, 12'(REG_STALL + 16 * m + 4), 1000);
      wb(1, 12'(REG_STALL + 16 * m + 8), 3);
      wb(1, 12'(REG_UL + 16 * m), 1 + 2 * m); wb(1, 12'(REG_UL + 16 * m + 4), 400 - 100 * m);
      wb(1, 12'(REG_UL + 16 * m + 8), 2);
    end
    run_s <= 1'b1; tk(2);
    r_s <= 1100; tk(1); check("stall alarm", stall_alarm, 2'h3);
    check("stall early trip", stall_trip, 2'h0);
    tk(4); check("stall trip", stall_trip, 2'h1);
    r_s <= 990; tk(1); check("stall hold", stall_alarm[0], 990 * 100 > 1000 * 98);
    r_s <= 975; repeat (3) @(posedge sys_clk);
    check("stall drop", {stall_alarm, stall_trip}, 4'h0);
    r_s <= 1100; tk(1); r_s <= 500; tk(5); check("short excursion", stall_trip, 2'h0);
    wb(1, REG_RDLY, 2); r_s <= 1100; repeat (3) @(posedge sys_clk);
    check("run delay hold", stall_alarm, 2'h0);
    tk(4); check("run delay pass", stall_alarm, 2'h3);
    wb(1, REG_RDLY, 0); r_s <= 250; tk(5);
    check("ul alarm", ul_alarm, 2'h3);
    check("ul trip", ul_trip, 2'h2);
    r_s <= 305; tk(1); check("ul hold", ul_alarm[1], 305 * 100 < 300 * 103);
    r_s <= 310; repeat (3) @(posedge sys_clk); check("ul drop", ul_alarm[1], 1'b0);
    run_s <= 1'b0; wb(1, 12'(REG_OC + 4), 800); wb(1, 12'(REG_OC + 8), 1);
    wb(1, 12'(REG_OC + 12), 1000);
    for (m = 0; m < 4; m++)
    begin
      hi = 16'(801 + ($random(seed) & 32'h3ff));
      lo = 16'($random(seed) & 32'h1ff);
      wb(1, REG_OC, 3 + 4 * m);
      f_s <= (m == 1 || m == 2) ? lo : hi; r_s <= (m == 1) ? hi : lo; n_s <= (m == 2) ? hi : lo;
      repeat (4) @(posedge sys_clk); check("oc method hi", oc_pickup, 2'h1);
      f_s <= (m == 1 || m == 2) ? hi : lo; r_s <= (m == 1) ? lo : hi; n_s <= (m == 2) ? lo : hi;
      repeat (4) @(posedge sys_clk); check("oc method lo", oc_pickup[0], 1'b0);
    end
    f_s <= 900; wb(1, REG_OC, 1); repeat (3) @(posedge sys_clk);
    check("oc directional", oc_pickup[0], 1'b0);
    {f_s, vp_s, fw_s} <= {16'd500, 16'd500, 1'b1}; wb(1, REG_OC, 16'h11); tk(3);
    check("oc restraint", oc_pickup[0], oc_exp(500, 800, 500, 1000));
    check("oc trip", oc_trip[0], 1'b1);
    wb(1, REG_OC, 16'h31); repeat (3) @(posedge sys_clk);
    check("oc vmode", oc_pickup[0], oc_exp(500, 800, 1000, 1000));
    wb(1, REG_CTRL, 2); repeat (3) @(posedge sys_clk);
    check("active set", active_set, 2'h2);
    check("empty set", oc_pickup[0], 1'b0);
    wb(1, REG_CTRL, 16'h000e); ad_s <= 1'b1; repeat (4) @(posedge sys_clk);
    check("adaptive pin", active_set, 2'h1);
    ad_s <= 1'b0; wb(1, REG_AVLIM, 600); repeat (3) @(posedge sys_clk);
    check("adaptive undervoltage", active_set, 2'h1);
    report_and_stop;
  end
endmodule : testbench
bind mcs_top mcs_sva i_sva (.sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .motor_run(motor_run),
  .stall_alarm(stall_alarm), .stall_trip(stall_trip), .oc_pickup(oc_pickup), .oc_trip(oc_trip));
